// ===== port_pad_pkg.sv
// Constants and carrier types shared by the port pin and pad control logic
package port_pad_pkg;

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam int          ADDR_W          = 20;
   localparam logic [15:0] IDX_PAD_CTRL    = 16'hF0AA;
   localparam logic [15:0] IDX_PORT_LATCH  = 16'hF0B0;
   localparam logic [15:0] IDX_PORT_DIR    = 16'hF0B1;
   localparam logic [15:0] IDX_PIN_STATE   = 16'hF0B2;
   localparam logic [19:0] ADDR_PAD_CTRL   = {2'h0, IDX_PAD_CTRL, 2'h0};
   localparam logic [19:0] ADDR_PORT_LATCH = {2'h0, IDX_PORT_LATCH, 2'h0};
   localparam logic [19:0] ADDR_PORT_DIR   = {2'h0, IDX_PORT_DIR, 2'h0};
   localparam logic [19:0] ADDR_PIN_STATE  = {2'h0, IDX_PIN_STATE, 2'h0};

   // ------------------------------------------------------------
   // Pad control field layout and reset values
   // ------------------------------------------------------------
   localparam int         STROBE_EDGE_LSB = 0;
   localparam int         STROBE_CUR_LSB  = 2;
   localparam int         ALE_EDGE_LSB    = 4;
   localparam int         ALE_CUR_LSB     = 6;
   localparam logic [7:0] PAD_CTRL_RESET  = 8'h00;
   localparam logic [7:0] LATCH_RESET     = 8'h00;
   localparam logic [7:0] DIR_RESET       = 8'h00;

   // ------------------------------------------------------------
   // Field encodings
   // ------------------------------------------------------------
   localparam logic [1:0] EDGE_CODE_FAST = 2'h0;
   localparam logic [1:0] EDGE_CODE_SLOW = 2'h1;
   localparam logic [1:0] CUR_CODE_HIGH  = 2'h0;
   localparam logic [1:0] CUR_CODE_DYN   = 2'h1;
   localparam logic [1:0] CUR_CODE_LOW   = 2'h2;

   typedef enum logic [1:0] {
      CUR_HIGH,
      CUR_DYNAMIC,
      CUR_LOW
   } current_mode_t;

   // Settings applied to one group of pads
   typedef struct packed {
      logic          slow_edge;
      current_mode_t current;
   } pad_drive_t;

   localparam pad_drive_t PAD_DRIVE_RESET = '{slow_edge: 1'b0, current: CUR_HIGH};

endpackage

// ===== port_pad_ctrl.sv
// Port pin direction, latch, alternate function and strobe pad control logic
//
// The APB interface to the registers was decided locally.

module port_pad_ctrl
   import port_pad_pkg::*;
#(
   parameter int         W             = 8,
   parameter logic [7:0] AUTO_DIR_MASK = 8'h00,
   parameter logic [7:0] PWM_MASK      = 8'h00
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [W-1:0]      pin_i,
   output logic      [W-1:0]      pin_o,
   output logic      [W-1:0]      pin_oe,
   input  wire logic [W-1:0]      alt_func_en,
   input  wire logic [W-1:0]      alt_data_out,
   input  wire logic [W-1:0]      alt_bus_dir,
   input  wire logic              seg_enable,
   input  wire logic [W-1:0]      seg_addr,
   output logic      [W-1:0]      alt_data_in,
   output pad_drive_t             strobe_pad,
   output pad_drive_t             latch_enable_pad
);

   // ------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------
   // Address compare, used by read, write and error decoding
   function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
      return a == r;
   endfunction

   // Reserved edge codes fall back to fast, the safer setting
   function automatic logic edge_slow(input logic [1:0] code);
      return code == EDGE_CODE_SLOW;
   endfunction

   // Reserved current code falls back to full strength
   function automatic current_mode_t cur_mode(input logic [1:0] code);
      current_mode_t m;
      m = CUR_HIGH;
      case (code)
         CUR_CODE_HIGH: m = CUR_HIGH;
         CUR_CODE_DYN:  m = CUR_DYNAMIC;
         CUR_CODE_LOW:  m = CUR_LOW;
         default:       m = CUR_HIGH;
      endcase
      return m;
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [7:0]   pad_ctrl_q, pad_ctrl_d;
   logic [W-1:0] latch_q, latch_d;
   logic [W-1:0] dir_q, dir_d;
   logic [W-1:0] pin_meta_q, pin_sync_q;
   logic [31:0]  prdata_q, prdata_d;
   logic         pready_q, pready_d;
   logic         pslverr_q, pslverr_d;
   logic [W-1:0] pin_o_q, pin_o_d;
   logic [W-1:0] pin_oe_q, pin_oe_d;
   logic [W-1:0] alt_in_q, alt_in_d;
   pad_drive_t   strobe_q, strobe_d;
   pad_drive_t   ale_q, ale_d;
   logic         setup, access_wr;
   logic         mapped;

   // ------------------------------------------------------------
   // APB slave: one wait-free access, answer registered in setup
   // ------------------------------------------------------------
   always_comb begin
      setup     = psel & ~penable;
      access_wr = psel & penable & pready_q & pwrite;
      mapped    = addr_is(paddr, ADDR_PAD_CTRL) | addr_is(paddr, ADDR_PORT_LATCH)
                | addr_is(paddr, ADDR_PORT_DIR) | addr_is(paddr, ADDR_PIN_STATE);
      pready_d  = setup;
      pslverr_d = setup & ~mapped;
      prdata_d  = 32'h0000_0000;
      if (setup & ~pwrite) begin
         if (addr_is(paddr, ADDR_PAD_CTRL)) begin
            prdata_d = {24'h00_0000, pad_ctrl_q};
         end else if (addr_is(paddr, ADDR_PORT_LATCH)) begin
            prdata_d = {{(32-W){1'b0}}, latch_q};
         end else if (addr_is(paddr, ADDR_PORT_DIR)) begin
            prdata_d = {{(32-W){1'b0}}, dir_q};
         end else if (addr_is(paddr, ADDR_PIN_STATE)) begin
            prdata_d = {{(32-W){1'b0}}, pin_sync_q};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // ------------------------------------------------------------
   // Software registers; writes land on the access edge
   // ------------------------------------------------------------
   always_comb begin
      pad_ctrl_d = pad_ctrl_q;
      latch_d    = latch_q;
      dir_d      = dir_q;
      if (access_wr) begin
         if (addr_is(paddr, ADDR_PAD_CTRL)) begin
            pad_ctrl_d = pwdata[7:0];
         end
         if (addr_is(paddr, ADDR_PORT_LATCH)) begin
            latch_d = pwdata[W-1:0];
         end
         if (addr_is(paddr, ADDR_PORT_DIR)) begin
            dir_d = pwdata[W-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_ctrl_q <= PAD_CTRL_RESET;
         latch_q    <= LATCH_RESET[W-1:0];
         dir_q      <= DIR_RESET[W-1:0];
      end else begin
         pad_ctrl_q <= pad_ctrl_d;
         latch_q    <= latch_d;
         dir_q      <= dir_d;
      end
   end

   // ------------------------------------------------------------
   // Pad drive decode
   // ------------------------------------------------------------
   always_comb begin
      strobe_d.slow_edge = edge_slow(pad_ctrl_q[STROBE_EDGE_LSB +: 2]);
      strobe_d.current   = cur_mode(pad_ctrl_q[STROBE_CUR_LSB +: 2]);
      ale_d.slow_edge    = edge_slow(pad_ctrl_q[ALE_EDGE_LSB +: 2]);
      ale_d.current      = cur_mode(pad_ctrl_q[ALE_CUR_LSB +: 2]);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strobe_q <= PAD_DRIVE_RESET;
         ale_q    <= PAD_DRIVE_RESET;
      end else begin
         strobe_q <= strobe_d;
         ale_q    <= ale_d;
      end
   end

   // ------------------------------------------------------------
   // Pin input synchroniser
   // ------------------------------------------------------------
   // Pins are asynchronous; the first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
      end else begin
         pin_meta_q <= pin_i;
         pin_sync_q <= pin_meta_q;
      end
   end

   // ------------------------------------------------------------
   // Per-pin output, direction and alternate input path
   // ------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_pin
         logic auto_dir, dir_eff, alt_val, drive_val;
         always_comb begin
            auto_dir  = AUTO_DIR_MASK[i] & alt_func_en[i];
            dir_eff   = auto_dir ? alt_bus_dir[i] : dir_q[i];
            alt_val   = seg_enable ? seg_addr[i] : alt_data_out[i];
            if (!alt_func_en[i]) begin
               drive_val = latch_q[i];
            end else if (auto_dir | PWM_MASK[i]) begin
               drive_val = alt_val;
            end else begin
               drive_val = latch_q[i] & alt_val;
            end
            pin_o_d[i]  = drive_val;
            pin_oe_d[i] = dir_eff;
            alt_in_d[i] = dir_eff ? drive_val : pin_sync_q[i];
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_o_q  <= '0;
         pin_oe_q <= '0;
         alt_in_q <= '0;
      end else begin
         pin_o_q  <= pin_o_d;
         pin_oe_q <= pin_oe_d;
         alt_in_q <= alt_in_d;
      end
   end

   // Outputs, all from flops
   assign prdata           = prdata_q;
   assign pready           = pready_q;
   assign pslverr          = pslverr_q;
   assign pin_o            = pin_o_q;
   assign pin_oe           = pin_oe_q;
   assign alt_data_in      = alt_in_q;
   assign strobe_pad       = strobe_q;
   assign latch_enable_pad = ale_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_pad_write;
      access_wr && addr_is(paddr, ADDR_PAD_CTRL);
   endsequence

   sequence s_pad_read_setup;
      setup && !pwrite && addr_is(paddr, ADDR_PAD_CTRL);
   endsequence

   property p_pad_store;
      s_pad_write |=> pad_ctrl_q == $past(pwdata[7:0]);
   endproperty
   a_pad_store: assert property (p_pad_store) else $error("pad control not stored");

   property p_strobe_edge;
      s_pad_write ##1 1'b1 |=>
         strobe_pad.slow_edge == ($past(pad_ctrl_q[STROBE_EDGE_LSB +: 2]) == EDGE_CODE_SLOW);
   endproperty
   a_strobe_edge: assert property (p_strobe_edge) else $error("strobe edge wrong");

   property p_strobe_cur_low;
      pad_ctrl_q[STROBE_CUR_LSB +: 2] == CUR_CODE_LOW |=> strobe_pad.current == CUR_LOW;
   endproperty
   a_strobe_cur_low: assert property (p_strobe_cur_low) else $error("strobe low current");

   property p_ale_edge;
      pad_ctrl_q[ALE_EDGE_LSB +: 2] == EDGE_CODE_SLOW |=> latch_enable_pad.slow_edge;
   endproperty
   a_ale_edge: assert property (p_ale_edge) else $error("latch enable edge");

   property p_ale_cur_dyn;
      pad_ctrl_q[ALE_CUR_LSB +: 2] == CUR_CODE_DYN |=> latch_enable_pad.current == CUR_DYNAMIC;
   endproperty
   a_ale_cur_dyn: assert property (p_ale_cur_dyn) else $error("latch enable current");

   property p_edge_fast;
      pad_ctrl_q[STROBE_EDGE_LSB +: 2] == EDGE_CODE_FAST |=> !strobe_pad.slow_edge;
   endproperty
   a_edge_fast: assert property (p_edge_fast) else $error("fast edge code");

   property p_read_high_zero;
      s_pad_read_setup |=> pready && prdata[31:8] == 24'h00_0000 && prdata[7:0] == pad_ctrl_q;
   endproperty
   a_read_high_zero: assert property (p_read_high_zero) else $error("pad read data");

   property p_dir_out;
      (alt_func_en == '0) |=> pin_oe == $past(dir_q) && pin_o == $past(latch_q);
   endproperty
   a_dir_out: assert property (p_dir_out) else $error("plain pin path");

   // Checked per pin, so any plain output pin exercises it
   property p_loopback;
      |(~alt_func_en & dir_q)
         |=> ($past(~alt_func_en & dir_q) & (alt_data_in ^ $past(latch_q))) == '0;
   endproperty
   a_loopback: assert property (p_loopback) else $error("alternate input loopback");

   property p_write_answer;
      setup |=> pready ##1 !pready;
   endproperty
   a_write_answer: assert property (p_write_answer) else $error("bus answer timing");

endmodule

// ===== pin_partner.sv
// Behavioural model of the external devices wired to the port pins
module pin_partner #(
   parameter int W = 8
) (
   input  wire logic         pclk,
   input  wire logic [W-1:0] pin_o,
   input  wire logic [W-1:0] pin_oe,
   input  wire logic [W-1:0] ext_val,
   input  wire logic [W-1:0] ext_en,
   output logic      [W-1:0] pin_i
);
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // Undriven lines
   // ------------------------------------------------------------
   // No pull on these lines, so a free line toggles every cycle
   logic [W-1:0] float_q = '0;

   // Toggle pattern for lines that nobody drives
   always @(posedge pclk) begin
      float_q <= ~float_q;
   end

   // ------------------------------------------------------------
   // Wire level
   // ------------------------------------------------------------
   // external device drives only input pins
   assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en & float_q);
endmodule

// ===== port_alt_function_pad_ctrl_tb.sv
// Self-checking bench for the port pin and strobe pad control block
module port_alt_function_pad_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import port_pad_pkg::*;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam logic [7:0] AUTO = 8'h0F;
   localparam logic [7:0] PWM  = 8'h30;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic        seg     = 1'b0;
   logic [19:0] paddr   = '0;
   logic [31:0] pwdata  = '0;
   logic [31:0] prdata, rdat;
   logic        pready, pslverr, rerr;
   logic [7:0]  pin_i, pin_o, pin_oe, alt_data_in;
   logic [7:0]  afe = '0, ado = '0, abd = '0, sa = '0, ext_val = '0, ext_en = 8'hFF;
   logic [7:0]  lv, dv, alt, au, oe, sl, av, val, wv;
   logic [1:0]  se, sc, ae, ac;
   pad_drive_t  strobe_pad, latch_enable_pad;
   int          mismatches   = 0;
   int          total_checks = 0;
   integer      seed         = 32'h4B9F0A7D;

   // 40 MHz clock
   always #12.5 pclk = ~pclk;

   port_pad_ctrl #(.W(8), .AUTO_DIR_MASK(AUTO), .PWM_MASK(PWM)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o),
      .pin_oe(pin_oe), .alt_func_en(afe), .alt_data_out(ado),
      .alt_bus_dir(abd), .seg_enable(seg), .seg_addr(sa),
      .alt_data_in(alt_data_in), .strobe_pad(strobe_pad),
      .latch_enable_pad(latch_enable_pad));

   pin_partner #(.W(8)) partner (
      .pclk(pclk), .pin_o(pin_o), .pin_oe(pin_oe), .ext_val(ext_val),
      .ext_en(ext_en), .pin_i(pin_i));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // One APB transfer; waits for pready with a bound, never a fixed count
   task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) mismatches++;
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   // Pad flop, two sync flops, input flop, read before the last lands; one spare
   task automatic settle;
      repeat (6) @(posedge pclk);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, ADDR_PAD_CTRL, 0);  check(rdat, 0, "pad reset");
      apb(0, ADDR_PORT_DIR, 0);  check(rdat, 0, "dir reset");
      check(pin_oe, 0, "oe reset");
      check(strobe_pad, PAD_DRIVE_RESET, "strobe reset");
      $display("test reset done");
      // only defined edge and current codes are written
      for (int i = 0; i < 12; i++) begin
         se = 2'($random(seed) & 1); ae = 2'($random(seed) & 1);
         sc = 2'($unsigned($random(seed)) % 3); ac = 2'($unsigned($random(seed)) % 3);
         apb(1, ADDR_PAD_CTRL, {24'($random(seed)), ac, ae, sc, se});
         apb(0, ADDR_PAD_CTRL, 0);
         check(rdat, {24'h0, ac, ae, sc, se}, "pad read");
         check(strobe_pad, {se == 2'h1, sc}, "strobe pad");
         check(latch_enable_pad, {ae == 2'h1, ac}, "ale pad");
      end
      $display("test pad fields done");
      // Unmapped place and read-only pin state
      apb(1, ADDR_PORT_LATCH, 32'h0000005A);
      apb(1, 20'h00010, 32'h000000FF); check(rerr, 1, "unmapped write err");
      apb(0, 20'h00010, 0); check(rerr, 1, "unmapped read err");
      check(rdat, 0, "unmapped read");
      apb(1, ADDR_PIN_STATE, 32'h000000FF); check(rerr, 0, "state write err");
      apb(0, ADDR_PORT_LATCH, 0); check(rdat, 32'h0000005A, "latch kept");
      $display("test refusals done");
      // direction set before alternate enable; pairs kept apart
      for (int i = 0; i < 32; i++) begin
         lv = 8'($random(seed)); dv = 8'($random(seed));
         // latch written before the driver is enabled
         apb(1, ADDR_PORT_LATCH, {24'h0, lv});
         apb(1, ADDR_PORT_DIR, {24'h0, dv});
         @(posedge pclk);
         afe <= 8'($random(seed)); ado <= 8'($random(seed)); abd <= 8'($random(seed));
         sa <= 8'($random(seed)); seg <= 1'($random(seed)); ext_val <= 8'($random(seed));
         settle;
         alt = seg ? sa : ado;
         au = AUTO & afe;
         oe = (au & abd) | (~au & dv);
         sl = AUTO | PWM;
         av = (sl & alt) | (~sl & lv & alt);
         val = (afe & av) | (~afe & lv);
         wv = (oe & val) | (~oe & ext_val);
         check(pin_oe, oe, "pin oe");
         check(pin_o & oe, val & oe, "pin out");
         check(alt_data_in, wv, "alt in");
         apb(0, ADDR_PIN_STATE, 0); check(rdat, {24'h0, wv}, "pin state");
         apb(0, ADDR_PORT_DIR, 0); check(rdat, {24'h0, dv}, "dir read");
      end
      $display("test pin traffic done");
      complete_run;
   end

   // Watchdog, far beyond the expected run length
   initial begin
      #500000;
      mismatches++;
      complete_run;
   end
endmodule
